/* File: pkg/hssq_pkg.sv */
// Constants and types for the hot-swap supply sequencer host controller
package hssq_pkg;

   localparam int          CLK_MHZ          = 50;
   // Backplane supply ramp time plus margin before the delayed on edge
   localparam int          ON_DELAY_US      = 1000;
   localparam int          ON_DELAY_CYC     = ON_DELAY_US * CLK_MHZ;
   // Device power-good drop settle time
   localparam int          PG_SETTLE_US     = 20;
   localparam int          PG_SETTLE_CYC    = PG_SETTLE_US * CLK_MHZ;
   // Least high time of an on-request toggle pulse
   localparam int          PULSE_US         = 1;
   localparam int          PULSE_CYC        = PULSE_US * CLK_MHZ;
   localparam int          CNT_W            = 24;
   // Cycles our own released pull still shows through the sampling stages
   localparam int          OWN_PULL_CYC     = 7;

   localparam logic [1:0]  SYNC_RST         = 2'h3;

   typedef struct packed {
      logic power_good_n;
      logic fault_n;
      logic card_reset_n;
   } hssq_status_t;

   typedef struct packed {
      logic on_req_n;
      logic fault_drive;
   } hssq_drive_t;

   typedef enum logic [2:0] {
      HSSQ_OFF,
      HSSQ_WAIT_SUPPLY,
      HSSQ_ON_LOW,
      HSSQ_RUN,
      HSSQ_TOGGLE,
      HSSQ_FORCE
   } hssq_state_t;

endpackage : hssq_pkg

/* File: logic/hssq_host.sv */
// Host controller that drives the hot-swap supply sequencer through its pins
`timescale 1ns/1ps
module hssq_host
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   enable,
   input  wire logic                   backplane_up,
   input  wire logic                   force_off,
   input  wire logic                   retry,
   input  wire hssq_pkg::hssq_status_t status_in,
   output logic                        on_req_n,
   output logic                        fault_out,
   output logic                        fault_oe,
   output logic                        card_ready,
   output logic                        fault_seen,
   output logic                        powered
);
   import hssq_pkg::*;

   logic [2:0]   pg_s_q;
   logic [2:0]   fl_s_q;
   logic [2:0]   rs_s_q;
   logic         pg_n_q;
   logic         fl_n_q;
   logic         rs_n_q;
   logic         fl_n_d;
   hssq_state_t  state_q;
   logic [CNT_W-1:0] cnt_q;
   hssq_drive_t  drv_q;
   logic [2:0]   quiet_q;

   function automatic logic agree(input logic [2:0] s, input logic cur);
      agree = (s[2] == s[1]) ? s[2] : cur;
   endfunction : agree

   // Either the user or the backplane can end a power cycle
   function automatic logic want_off(input logic en, input logic bp);
      want_off = !en || !bp;
   endfunction : want_off

   // Three-stage sampling of power-good; idles high so no false edge after reset
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pg_s_q <= 3'h7;
         pg_n_q <= 1'b1;
      end
      else
      begin
         pg_s_q <= {pg_s_q[1:0], status_in.power_good_n};
         pg_n_q <= agree(pg_s_q, pg_n_q);
      end
   end

   // Fault line idles high
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fl_s_q <= 3'h7;
         fl_n_q <= 1'b1;
      end
      else
      begin
         fl_s_q <= {fl_s_q[1:0], status_in.fault_n};
         fl_n_q <= fl_n_d;
      end
   end

   // Card reset idles low while the card is unpowered
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs_s_q <= 3'h0;
         rs_n_q <= 1'b0;
      end
      else
      begin
         rs_s_q <= {rs_s_q[1:0], status_in.card_reset_n};
         rs_n_q <= agree(rs_s_q, rs_n_q);
      end
   end

   assign fl_n_d = agree(fl_s_q, fl_n_q);

   // Sequencing of the on request and the fault line
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= HSSQ_OFF;
         cnt_q   <= '0;
         drv_q   <= '{on_req_n: 1'b1, fault_drive: 1'b0};
      end
      else
      begin
         case (state_q)
            HSSQ_OFF:
            begin
               drv_q.on_req_n    <= 1'b1;
               drv_q.fault_drive <= 1'b0;
               cnt_q             <= '0;
               if (enable && backplane_up)
                  state_q <= HSSQ_WAIT_SUPPLY;
            end
            HSSQ_WAIT_SUPPLY:
            begin
               // Held-low request replaced by a falling edge after supplies ramp
               if (want_off(enable, backplane_up))
                  state_q <= HSSQ_OFF;
               else if (cnt_q >= CNT_W'(ON_DELAY_CYC - 1))
               begin
                  drv_q.on_req_n <= 1'b0;
                  cnt_q          <= '0;
                  state_q        <= HSSQ_ON_LOW;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            HSSQ_ON_LOW, HSSQ_RUN:
            begin
               if (want_off(enable, backplane_up))
               begin
                  drv_q.on_req_n <= 1'b1;
                  state_q        <= HSSQ_OFF;
               end
               else if (force_off)
               begin
                  drv_q.fault_drive <= 1'b1;
                  cnt_q             <= '0;
                  state_q           <= HSSQ_FORCE;
               end
               else if (retry && !fl_n_q && (quiet_q == 3'h0))
               begin
                  // Toggle clears the device latch
                  drv_q.on_req_n <= 1'b1;
                  cnt_q          <= '0;
                  state_q        <= HSSQ_TOGGLE;
               end
               else
                  state_q <= HSSQ_RUN;
            end
            HSSQ_TOGGLE:
            begin
               if (want_off(enable, backplane_up))
                  state_q <= HSSQ_OFF;
               else if (cnt_q >= CNT_W'(PULSE_CYC - 1))
               begin
                  drv_q.on_req_n <= 1'b0;
                  cnt_q          <= '0;
                  state_q        <= HSSQ_ON_LOW;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            HSSQ_FORCE:
            begin
               // Release to run only after the device has settled its outputs; want_off releases at once
               if (want_off(enable, backplane_up))
               begin
                  drv_q.on_req_n    <= 1'b1;
                  drv_q.fault_drive <= 1'b0;
                  state_q           <= HSSQ_OFF;
               end
               else if (!force_off && cnt_q >= CNT_W'(PG_SETTLE_CYC - 1))
               begin
                  drv_q.fault_drive <= 1'b0;
                  cnt_q             <= '0;
                  state_q           <= HSSQ_RUN;
               end
               else if (cnt_q < CNT_W'(PG_SETTLE_CYC - 1))
                  cnt_q <= cnt_q + 1'b1;
            end
            default:
               state_q <= HSSQ_OFF;
         endcase
      end
   end

   // Own pull still reads low through the sampling stages after release
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         quiet_q <= 3'h0;
      else if (drv_q.fault_drive)
         quiet_q <= 3'(OWN_PULL_CYC);
      else if (quiet_q != 3'h0)
         quiet_q <= quiet_q - 1'b1;
   end

   // Pin drive registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         on_req_n  <= 1'b1;
         fault_out <= 1'b0;
         fault_oe  <= 1'b0;
      end
      else
      begin
         on_req_n  <= drv_q.on_req_n;
         // Open-drain pin only ever pulls low
         fault_out <= 1'b0;
         fault_oe  <= drv_q.fault_drive;
      end
   end

   // Status registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         card_ready <= 1'b0;
         fault_seen <= 1'b0;
         powered    <= 1'b0;
      end
      else
      begin
         // Card usable only with power good and card reset released
         card_ready <= !pg_n_q && rs_n_q && (state_q == HSSQ_RUN);
         // Our own pull also reads low, even a few cycles after release; exclude it
         fault_seen <= !fl_n_q && !drv_q.fault_drive && (quiet_q == 3'h0) && (state_q == HSSQ_RUN);
         powered    <= !pg_n_q;
      end
   end

endmodule : hssq_host

/* File: bench/hssq_host_chk.sv */
// Checker on the host controller pins
`timescale 1ns/1ps
module hssq_host_chk
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic backplane_up,
   input wire logic force_off,
   input wire logic card_ready,
   input wire logic on_req_n,
   input wire logic fault_out,
   input wire logic fault_oe
);
   import hssq_pkg::*;
   logic [CNT_W-1:0] bp_up_cnt_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Cycles since the backplane came up, saturating
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         bp_up_cnt_q <= '0;
      else if (!backplane_up)
         bp_up_cnt_q <= '0;
      else if (bp_up_cnt_q != '1)
         bp_up_cnt_q <= bp_up_cnt_q + 1'b1;
   end
   property p_on_delay; $fell(on_req_n) |-> bp_up_cnt_q >= CNT_W'(ON_DELAY_CYC); endproperty
   a_on_delay: assert property (p_on_delay) else $error("on request too early");
   property p_pin_low; fault_oe |-> !fault_out; endproperty
   a_pin_low: assert property (p_pin_low) else $error("fault pin high");
   property p_pull; force_off && card_ready |-> ##[1:8] fault_oe; endproperty
   a_pull: assert property (p_pull) else $error("no pull");
   property p_toggle; $rose(on_req_n) |-> on_req_n[*8]; endproperty
   a_toggle: assert property (p_toggle) else $error("short toggle");
   property p_drop; !backplane_up |-> ##[0:8] on_req_n; endproperty
   a_drop: assert property (p_drop) else $error("on held");
   c_ready: cover property (card_ready);
   c_pull: cover property (fault_oe);
   c_toggle: cover property ($rose(on_req_n));
endmodule : hssq_host_chk
bind hssq_host hssq_host_chk chk_u (.clock(clock), .rst_n(rst_n), .backplane_up(backplane_up),
   .force_off(force_off), .card_ready(card_ready), .on_req_n(on_req_n), .fault_out(fault_out),
   .fault_oe(fault_oe));

/* File: bench/hssq_dev.sv */
// Behavioural model of the supply switch device
`timescale 1ns/1ps
module hssq_dev
(
   input  wire logic              clock,
   input  wire logic              on_req_n,
   input  wire logic              fault_oe,
   input  wire logic              trip,
   output hssq_pkg::hssq_status_t st
);
   import hssq_pkg::*;
   logic       up_q  = 1'b0;
   logic       lat_q = 1'b0;
   logic       pg_q  = 1'b0;
   logic [4:0] cnt_q = 5'h00;
   logic [1:0] flt_q = 2'h0;
   int         uv_q  = 0;
   // Inputs taken on the clock edge stand in for the device's input filters
   always_ff @(posedge clock)
      if (on_req_n || fault_oe)
         up_q <= 1'b0;
      else if ($fell(on_req_n) || $fell(fault_oe))
         up_q <= 1'b1;
   // Trip stands for any overcurrent or overheat, ignored while blanked
   always_ff @(posedge clock)
      flt_q <= (trip && cnt_q > 5'h07) ? flt_q + {1'b0, flt_q != 2'h3} : 2'h0;
   // Short trips never reach the latch
   always_ff @(posedge clock)
      lat_q <= on_req_n ? 1'b0 : lat_q | (trip && flt_q == 2'h3);
   always_ff @(posedge clock)
      cnt_q <= (!up_q || lat_q) ? 5'h00 : cnt_q + {4'h0, !cnt_q[4]};
   // Power-good lingers a settle time after the rails drop
   always_ff @(posedge clock)
   begin
      if (cnt_q > 5'h07)
      begin
         pg_q <= 1'b1;
         uv_q <= 0;
      end
      else if (uv_q != PG_SETTLE_CYC - 1)
         uv_q <= uv_q + 1;
      else
         pg_q <= 1'b0;
   end
   assign st.power_good_n = !pg_q;
   assign st.card_reset_n = cnt_q[4];
   assign st.fault_n      = !(lat_q || fault_oe);
endmodule : hssq_dev

/* File: bench/tb_top.sv */
// Self-checking bench for the host controller
`timescale 1ns/1ps
module tb_top;
   import hssq_pkg::*;
   logic         clock, rst_n, enable, backplane_up, force_off, retry, trip;
   logic         on_req_n, fault_out, fault_oe, card_ready, fault_seen, powered;
   hssq_status_t st;
   int           num_errors = 0;
   int           checks_done = 0;
   hssq_host dut_u (.clock(clock), .rst_n(rst_n), .enable(enable), .backplane_up(backplane_up),
      .force_off(force_off), .retry(retry), .status_in(st), .on_req_n(on_req_n), .fault_out(fault_out),
      .fault_oe(fault_oe), .card_ready(card_ready), .fault_seen(fault_seen), .powered(powered));
   hssq_dev dev_u (.clock(clock), .on_req_n(on_req_n), .fault_oe(fault_oe), .trip(trip), .st(st));
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task chk(string what, logic seen, logic exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk
   task tick(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // Bounded wait; a restart may pass through the full on delay
   task wait_ready;
      for (int i = 0; i < ON_DELAY_CYC + 500 && card_ready !== 1'b1; i++)
         tick(1);
      chk("card_ready", card_ready, 1'b1);
   endtask : wait_ready
   task conclude;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // Delayed on edge only once the backplane has been up long enough
   task scen_startup;
      backplane_up = 1'b1;
      tick(ON_DELAY_CYC + 1);
      chk("on_req_n early", on_req_n, 1'b1);
      tick(1);
      chk("on_req_n falls", on_req_n, 1'b0);
      chk("fault_out", fault_out, 1'b0);
      chk("fault_oe idle", fault_oe, 1'b0);
      wait_ready();
      chk("powered", powered, 1'b1);
   endtask : scen_startup
   // External pull stops the rails without a latched fault
   task scen_force;
      force_off = 1'b1;
      tick(PG_SETTLE_CYC + 20);
      chk("fault_oe", fault_oe, 1'b1);
      chk("fault_out pulled", fault_out, 1'b0);
      chk("ready off", card_ready, 1'b0);
      chk("no latch", fault_seen, 1'b0);
      chk("power dropped", powered, 1'b0);
      force_off = 1'b0;
      tick(4);
      chk("no false fault", fault_seen, 1'b0);
      tick(8);
      chk("pull released", fault_oe, 1'b0);
      wait_ready();
   endtask : scen_force
   // Lasting trip latches a fault; releasing the trip keeps it, an on toggle clears it
   task scen_trip;
      trip = 1'b1;
      tick(2);
      trip = 1'b0;
      tick(12);
      chk("short trip", fault_seen, 1'b0);
      trip = 1'b1;
      tick(12);
      chk("fault_seen", fault_seen, 1'b1);
      chk("ready tripped", card_ready, 1'b0);
      trip = 1'b0;
      tick(20);
      chk("latched", fault_seen, 1'b1);
      chk("no toggle yet", on_req_n, 1'b0);
      retry = 1'b1;
      tick(3);
      chk("toggle high", on_req_n, 1'b1);
      retry = 1'b0;
      wait_ready();
      chk("fault cleared", fault_seen, 1'b0);
   endtask : scen_trip
   initial
   begin
      rst_n = 1'b0;
      enable = 1'b1;
      backplane_up = 1'b0;
      force_off = 1'b0;
      retry = 1'b0;
      trip = 1'b0;
      tick(16);
      rst_n = 1'b1;
      tick(12);
      chk("on_req_n reset", on_req_n, 1'b1);
      scen_startup();
      scen_force();
      scen_trip();
      conclude();
   end
   initial
   begin
      // One full on delay plus a margin for the short restarts
      #(20ns * (ON_DELAY_CYC + 20000));
      num_errors++;
      conclude();
   end
endmodule : tb_top
